// ===== hw/ois_defines.svh
// Constants for the octal input serializer
`ifndef OIS_DEFINES_SVH
`define OIS_DEFINES_SVH
`define OIS_CLK_HZ        10000000
`define OIS_DB_LONG_MS    3
`define OIS_DB_SHORT_MS   1
`define OIS_DB_LONG_CYC   ((`OIS_CLK_HZ / 1000) * `OIS_DB_LONG_MS)
`define OIS_DB_SHORT_CYC  ((`OIS_CLK_HZ / 1000) * `OIS_DB_SHORT_MS)
`define OIS_CHANNELS      8
`define OIS_CNT_W         16
`define OIS_STAT_OVERTEMP 0
`define OIS_STAT_FRAME    1
`define OIS_REG_STATUS    4'h0
`define OIS_REG_MASK      4'h1
`define OIS_REG_TEMP_TRIP 4'h2
`define OIS_REG_TEMP_NOW  4'h3
`define OIS_REG_INPUTS    4'h4
`define OIS_TRIP_RESET    8'h96
`endif

// ===== hw/ois_pkg.sv
// Types for the octal input serializer
package ois_pkg;
  typedef enum logic [1:0] {
    OIS_DB_RESERVED = 2'b00,
    OIS_DB_BYPASS   = 2'b01,
    OIS_DB_SHORT    = 2'b10,
    OIS_DB_LONG     = 2'b11
  } ois_db_mode_e;
  typedef enum logic [1:0] {
    OIS_ST_LOAD  = 2'b00,
    OIS_ST_HOLD  = 2'b01,
    OIS_ST_SHIFT = 2'b10
  } ois_state_e;
endpackage : ois_pkg

// ===== hw/ois_debounce.sv
// One-channel debounce filter
`timescale 1ns/100ps
`include "ois_defines.svh"
module ois_debounce #(
  parameter int CNT_W = `OIS_CNT_W
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Filter control
  input  wire logic [CNT_W-1:0] hold_cycles,
  input  wire logic             bypass,
  // Level
  input  wire logic             raw_in,
  output logic                  clean_out
);
  logic [CNT_W-1:0] cnt_r;
  logic             state_r;
  wire              differs  = raw_in != state_r;
  wire              expired  = (cnt_r + 1'b1) >= hold_cycles;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_r   <= '0;
      state_r <= 1'b0;
    end else if (!differs) begin
      cnt_r <= '0;
    end else if (bypass || expired) begin
      state_r <= raw_in;
      cnt_r   <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
  assign clean_out = bypass ? raw_in : state_r;
endmodule : ois_debounce

// ===== hw/ois_temp_mon.sv
// Over-temperature comparator with hysteresis-free trip
`timescale 1ns/100ps
module ois_temp_mon (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Temperature and trip point
  input  wire logic [7:0] temp_c,
  input  wire logic [7:0] trip_c,
  // Flag
  output logic            overtemp_flag_n
);
  logic hot_r;
  wire  hot_nxt = temp_c > trip_c;
  always_ff @(posedge core_clk) begin
    if (!rst_n) hot_r <= 1'b0;
    else        hot_r <= hot_nxt;
  end
  assign overtemp_flag_n = ~hot_r;
endmodule : ois_temp_mon

// ===== hw/ois_serializer.sv
// Octal input serializer top: debounce, parallel load, serial shift, status
// Behaviour
// - Load strobe low captures all eight debounced inputs into the register.
// - Load strobe high stops capture and holds the captured bits while shift enable is high.
// - Shift only while shift enable low and load strobe high.
// - Shift and serial output update on serial clock rising edge.
// - After eight shifts serial output follows the serial input chain.
// - Open debounce selects read as high through pull-ups.
// - Three debounce durations selected by grounding select pins.
// - Temperature flag high normally, low when overheated.
// - Selects: 11 is 3 ms, 10 is 1 ms, 01 bypass, 00 reserved.
// - A new level is accepted only after stable for the debounce time.
// - Both controls high leaves the register unchanged.
// - Temperature flag goes low above the programmable trip point, 150 degrees at reset.
`timescale 1ns/100ps
`include "ois_defines.svh"
module ois_serializer #(
  parameter int                  CHANNELS  = `OIS_CHANNELS,
  parameter int                  CNT_W     = `OIS_CNT_W,
  parameter logic [CNT_W-1:0]    DB_LONG   = CNT_W'(`OIS_DB_LONG_CYC),
  parameter logic [CNT_W-1:0]    DB_SHORT  = CNT_W'(`OIS_DB_SHORT_CYC)
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // Field side
  input  wire logic [CHANNELS-1:0] field_inputs,
  input  wire logic                debounce_sel0_drv,
  input  wire logic                debounce_sel0_oe,
  input  wire logic                debounce_sel1_drv,
  input  wire logic                debounce_sel1_oe,
  input  wire logic [7:0]          temp_c,
  // Host serial link
  input  wire logic                load_strobe_n,
  input  wire logic                shift_enable_n,
  input  wire logic                serial_clk,
  input  wire logic                serial_in,
  output logic                     serial_out,
  output logic                     overtemp_flag_n,
  // Register port
  input  wire logic [3:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,
  output logic                     irq
);
  // Pins undriven float high through the pull-ups
  wire debounce_sel0 = debounce_sel0_oe ? debounce_sel0_drv : 1'b1;
  wire debounce_sel1 = debounce_sel1_oe ? debounce_sel1_drv : 1'b1;

  ois_pkg::ois_db_mode_e db_mode;
  assign db_mode = ois_pkg::ois_db_mode_e'({debounce_sel1, debounce_sel0});

  function automatic logic [CNT_W-1:0] hold_for(input ois_pkg::ois_db_mode_e m);
    case (m)
      ois_pkg::OIS_DB_LONG:  hold_for = DB_LONG;
      ois_pkg::OIS_DB_SHORT: hold_for = DB_SHORT;
      default:               hold_for = '0;
    endcase
  endfunction : hold_for

  // Reserved code treated as bypass: safest defined behaviour
  wire             db_bypass = (db_mode == ois_pkg::OIS_DB_BYPASS) ||
                               (db_mode == ois_pkg::OIS_DB_RESERVED);
  wire [CNT_W-1:0] db_hold   = hold_for(db_mode);

  logic [CHANNELS-1:0] clean;
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_db
      ois_debounce #(.CNT_W(CNT_W)) u_db (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .hold_cycles (db_hold),
        .bypass      (db_bypass),
        .raw_in      (field_inputs[g]),
        .clean_out   (clean[g])
      );
    end
  endgenerate

  // Serial clock is sampled; edge found against its last value
  logic                sclk_q_r;
  logic [CHANNELS-1:0] shreg_r;
  logic [CHANNELS-1:0] shreg_nxt;
  logic [3:0]          shift_cnt_r;
  wire                 sclk_rise = serial_clk & ~sclk_q_r;
  wire                 do_load   = ~load_strobe_n;
  wire                 do_shift  = load_strobe_n & ~shift_enable_n & sclk_rise;

  ois_pkg::ois_state_e st;
  always_comb begin
    case ({do_load, ~shift_enable_n})
      2'b10, 2'b11: st = ois_pkg::OIS_ST_LOAD;
      2'b01:        st = ois_pkg::OIS_ST_SHIFT;
      default:      st = ois_pkg::OIS_ST_HOLD;
    endcase
  end

  // MSB leaves first, so field_inputs[CHANNELS-1] emerges first
  wire [CHANNELS-1:0] shreg_shl = {shreg_r[CHANNELS-2:0], serial_in};
  always_comb begin
    case (st)
      ois_pkg::OIS_ST_LOAD:  shreg_nxt = clean;
      ois_pkg::OIS_ST_SHIFT: shreg_nxt = sclk_rise ? shreg_shl : shreg_r;
      default:               shreg_nxt = shreg_r;
    endcase
  end

  logic frame_done_r;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sclk_q_r     <= 1'b0;
      shreg_r      <= '0;
      shift_cnt_r  <= 4'h0;
      frame_done_r <= 1'b0;
    end else begin
      sclk_q_r     <= serial_clk;
      shreg_r      <= shreg_nxt;
      frame_done_r <= 1'b0;
      if (do_load) begin
        shift_cnt_r <= 4'h0;
      end else if (do_shift && shift_cnt_r < 4'(CHANNELS)) begin
        shift_cnt_r  <= shift_cnt_r + 4'h1;
        frame_done_r <= (shift_cnt_r == 4'(CHANNELS - 1));
      end
    end
  end
  assign serial_out = shreg_r[CHANNELS-1];

  // Temperature monitor with programmable trip
  logic [7:0] trip_r;
  ois_temp_mon u_temp (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .temp_c          (temp_c),
    .trip_c          (trip_r),
    .overtemp_flag_n (overtemp_flag_n)
  );

  // Registers: status W1C, mask, trip, live readouts
  logic [1:0]  stat_r;
  logic [1:0]  mask_r;
  logic [31:0] rdata_r;
  logic        hot_q_r;
  wire         hot_rise = ~overtemp_flag_n & ~hot_q_r;
  wire         wr_stat  = reg_wr && reg_addr == `OIS_REG_STATUS;
  wire         wr_mask  = reg_wr && reg_addr == `OIS_REG_MASK;
  wire         wr_trip  = reg_wr && reg_addr == `OIS_REG_TEMP_TRIP;
  wire [1:0]   ev       = {frame_done_r, hot_rise};
  wire [1:0]   stat_nxt = (stat_r & ~(wr_stat ? reg_wdata[1:0] : 2'b00)) | ev;
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `OIS_REG_STATUS:    rd_mux = {30'h0, stat_r};
      `OIS_REG_MASK:      rd_mux = {30'h0, mask_r};
      `OIS_REG_TEMP_TRIP: rd_mux = {24'h0, trip_r};
      `OIS_REG_TEMP_NOW:  rd_mux = {23'h0, ~overtemp_flag_n, temp_c};
      `OIS_REG_INPUTS:    rd_mux = {16'h0, 8'(shreg_r), 8'(clean)};
      default:            rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stat_r  <= 2'h0;
      mask_r  <= 2'h0;
      trip_r  <= `OIS_TRIP_RESET;
      rdata_r <= 32'h0;
      hot_q_r <= 1'b0;
    end else begin
      stat_r  <= stat_nxt;
      hot_q_r <= ~overtemp_flag_n;
      if (wr_mask) mask_r <= reg_wdata[1:0];
      if (wr_trip) trip_r <= reg_wdata[7:0];
      rdata_r <= reg_rd ? rd_mux : 32'h0;
    end
  end
  assign reg_rdata = rdata_r;
  assign irq       = |(stat_r & mask_r);

  // Checks
  property p_load_capture;
    @(posedge core_clk) disable iff (!rst_n)
      !load_strobe_n |=> shreg_r == $past(clean);
  endproperty
  a_load_capture: assert property (p_load_capture) else $error("load missed");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_n)
      load_strobe_n && shift_enable_n |=> $stable(shreg_r);
  endproperty
  a_hold: assert property (p_hold) else $error("register moved while idle");

  property p_no_shift_wo_edge;
    @(posedge core_clk) disable iff (!rst_n)
      load_strobe_n && !sclk_rise |=> $stable(shreg_r);
  endproperty
  a_no_shift_wo_edge: assert property (p_no_shift_wo_edge) else $error("shift w/o edge");

  property p_shift;
    @(posedge core_clk) disable iff (!rst_n)
      do_shift |=> serial_out == $past(shreg_r[CHANNELS-2]) && shreg_r[0] == $past(serial_in);
  endproperty
  a_shift: assert property (p_shift) else $error("bad shift");

  property p_eight;
    @(posedge core_clk) disable iff (!rst_n)
      do_shift && shift_cnt_r == 4'(CHANNELS - 1) |=> ##1 frame_done_r == 1'b0 && stat_r[1];
  endproperty
  a_eight: assert property (p_eight) else $error("frame not flagged");

  property p_temp;
    @(posedge core_clk) disable iff (!rst_n)
      temp_c > trip_r && $stable(trip_r) |=> !overtemp_flag_n;
  endproperty
  a_temp: assert property (p_temp) else $error("overtemp missed");

  property p_cool;
    @(posedge core_clk) disable iff (!rst_n)
      temp_c <= trip_r && $stable(trip_r) |=> overtemp_flag_n;
  endproperty
  a_cool: assert property (p_cool) else $error("flag low when cool");

  property p_pullup;
    @(posedge core_clk) disable iff (!rst_n)
      !debounce_sel0_oe && !debounce_sel1_oe |-> db_hold == DB_LONG && !db_bypass;
  endproperty
  a_pullup: assert property (p_pullup) else $error("open selects not long");

  property p_irq;
    @(posedge core_clk) disable iff (!rst_n)
      hot_rise && mask_r[0] && !wr_mask |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing on unmasked event");

  property p_ev_hot;
    @(posedge core_clk) disable iff (!rst_n)
      hot_rise |=> stat_r[`OIS_STAT_OVERTEMP];
  endproperty
  a_ev_hot: assert property (p_ev_hot) else $error("overtemp event not latched");

  property p_sticky;
    @(posedge core_clk) disable iff (!rst_n)
      stat_r[`OIS_STAT_FRAME] && !wr_stat |=> stat_r[`OIS_STAT_FRAME];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit dropped");

  // Set beats clear, so a same-cycle event is left out
  property p_w1c;
    @(posedge core_clk) disable iff (!rst_n)
      wr_stat && reg_wdata[`OIS_STAT_FRAME] && !frame_done_r |=> !stat_r[`OIS_STAT_FRAME];
  endproperty
  a_w1c: assert property (p_w1c) else $error("status bit not cleared");

  property p_rd_idle;
    @(posedge core_clk) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");

  property p_trip_wr;
    @(posedge core_clk) disable iff (!rst_n)
      wr_trip |=> trip_r == $past(reg_wdata[7:0]);
  endproperty
  a_trip_wr: assert property (p_trip_wr) else $error("trip write lost");

  property p_sel_short;
    @(posedge core_clk) disable iff (!rst_n)
      debounce_sel1 && !debounce_sel0 |-> db_hold == DB_SHORT && !db_bypass;
  endproperty
  a_sel_short: assert property (p_sel_short) else $error("short select wrong");

  property p_sel_bypass;
    @(posedge core_clk) disable iff (!rst_n)
      !debounce_sel1 |-> db_bypass;
  endproperty
  a_sel_bypass: assert property (p_sel_bypass) else $error("bypass select wrong");

  property p_load_out;
    @(posedge core_clk) disable iff (!rst_n)
      !load_strobe_n |=> serial_out == $past(clean[CHANNELS-1]);
  endproperty
  a_load_out: assert property (p_load_out) else $error("wrong first bit");

  property p_frame_pulse;
    @(posedge core_clk) disable iff (!rst_n)
      frame_done_r |-> shift_cnt_r == 4'(CHANNELS);
  endproperty
  a_frame_pulse: assert property (p_frame_pulse) else $error("frame flag early");

  c_load:  cover property (@(posedge core_clk) !load_strobe_n ##1 load_strobe_n);
  c_shift: cover property (@(posedge core_clk) do_shift ##[1:20] do_shift);
  c_frame: cover property (@(posedge core_clk) frame_done_r);
  c_hot:   cover property (@(posedge core_clk) !overtemp_flag_n);
  c_irq:   cover property (@(posedge core_clk) irq);
endmodule : ois_serializer

// ===== dv/ois_host_model.sv
// Host model: load, enable and serial clock sequencing
`timescale 1ns/100ps
module ois_host_model (
  // Clock
  input  wire logic core_clk,
  // Serial link
  input  wire logic serial_out,
  output logic      load_strobe_n,
  output logic      shift_enable_n,
  output logic      serial_clk,
  output logic      serial_in,
  // Observed bits
  output logic      bit_valid,
  output logic      bit_val
);
  initial begin
    load_strobe_n  = 1'b1;
    shift_enable_n = 1'b1;
    serial_clk     = 1'b0;
    serial_in      = 1'b1;
    bit_valid      = 1'b0;
    bit_val        = 1'b0;
  end
  // Two cycles high, two low: slow enough for the core clock sampler
  task automatic pulse();
    @(posedge core_clk) serial_clk <= 1'b1;
    repeat (2) @(posedge core_clk);
    serial_clk <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : pulse
  task automatic load();
    @(posedge core_clk) load_strobe_n <= 1'b0;
    pulse();
    @(posedge core_clk) load_strobe_n <= 1'b1;
    pulse();
  endtask : load
  // Sample before each pulse, so the first sample is the first bit out
  task automatic shift(input logic [15:0] pat);
    @(posedge core_clk) shift_enable_n <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk) begin
        bit_valid <= 1'b1;
        bit_val   <= serial_out;
        serial_in <= pat[i];
      end
      @(posedge core_clk) bit_valid <= 1'b0;
      pulse();
    end
    @(posedge core_clk) shift_enable_n <= 1'b1;
    serial_in <= 1'b1;
  endtask : shift
endmodule : ois_host_model

// ===== dv/octal_input_serializer_bench.sv
// Self-checking bench for the octal input serializer
`timescale 1ns/100ps
`include "ois_defines.svh"
module octal_input_serializer_bench;
  logic        core_clk;
  logic        rst_n;
  logic [7:0]  field_inputs;
  logic        sel0_oe;
  logic        sel1_oe;
  logic        sel_drv;
  logic [7:0]  temp_c;
  logic        load_strobe_n;
  logic        shift_enable_n;
  logic        serial_clk;
  logic        serial_in;
  logic        serial_out;
  logic        overtemp_flag_n;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        irq;
  logic        bit_valid;
  logic        bit_val;
  logic        rd_d = 1'b0;
  logic        lvl_chk = 1'b0;
  logic [31:0] lfsr_r = 32'h0001_5535;
  logic [31:0] exp_q[$];
  int          fails = 0;
  int          compares = 0;
  int          hold_tab[4] = '{60, 30, 0, 0};
  logic [1:0]  oe_tab[4] = '{2'b00, 2'b01, 2'b10, 2'b11};
  // Short debounce counts keep the run brief
  ois_serializer #(.DB_LONG(16'h003C), .DB_SHORT(16'h001E)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .field_inputs(field_inputs),
    .debounce_sel0_drv(sel_drv), .debounce_sel0_oe(sel0_oe),
    .debounce_sel1_drv(sel_drv), .debounce_sel1_oe(sel1_oe), .temp_c(temp_c),
    .load_strobe_n(load_strobe_n), .shift_enable_n(shift_enable_n),
    .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
    .overtemp_flag_n(overtemp_flag_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  ois_host_model host (
    .core_clk(core_clk), .serial_out(serial_out), .load_strobe_n(load_strobe_n),
    .shift_enable_n(shift_enable_n), .serial_clk(serial_clk),
    .serial_in(serial_in), .bit_valid(bit_valid), .bit_val(bit_val));
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic take(input logic [31:0] got);
    if (exp_q.size() == 0) begin
      fails++;
      $display("unexpected at %0t: result without a note", $time);
    end else begin
      chk(got, exp_q.pop_front());
    end
  endtask : take
  // Results appear as sampled serial bits, read data or level checks
  always @(posedge core_clk) begin
    if (bit_valid) take({31'h0, bit_val});
    if (lvl_chk) take({30'h0, irq, overtemp_flag_n});
    if (rd_d) take(reg_rdata);
    rd_d <= reg_rd;
  end
  task automatic close_out();
    if (exp_q.size() != 0) begin
      fails++;
      $display("unexpected at %0t: %0d results never seen", $time, exp_q.size());
    end
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic lvl(input logic [1:0] e);
    repeat (3) @(posedge core_clk);
    exp_q.push_back({30'h0, e});
    lvl_chk <= 1'b1;
    @(posedge core_clk) lvl_chk <= 1'b0;
  endtask : lvl
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk) begin
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
    end
    @(posedge core_clk) reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge core_clk) begin
      reg_rd   <= 1'b1;
      reg_addr <= a;
    end
    @(posedge core_clk) reg_rd <= 1'b0;
  endtask : reg_read
  // Inputs change right after the load window closes
  task automatic frame(input logic [7:0] d, input logic [7:0] nxt);
    lfsr_r = lfsr_next(lfsr_r);
    for (int i = 7; i >= 0; i--) exp_q.push_back({31'h0, d[i]});
    for (int i = 0; i < 8; i++) exp_q.push_back({31'h0, lfsr_r[i]});
    host.load();
    field_inputs <= nxt;
    host.shift(lfsr_r[15:0]);
  endtask : frame
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    fails++;
    $display("unexpected at %0t: run did not finish", $time);
    close_out();
  end
  initial begin
    logic [7:0] a;
    int         h;
    rst_n = 1'b0;
    field_inputs = 8'h00;
    {sel1_oe, sel0_oe, sel_drv} = 3'h0;
    temp_c = 8'h64;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    lvl(2'b01);
    for (int m = 0; m < 4; m++) begin
      {sel1_oe, sel0_oe} <= oe_tab[m];
      h = hold_tab[m];
      lfsr_r = lfsr_next(lfsr_r);
      a = lfsr_r[7:0];
      field_inputs <= a;
      repeat (h + 12) @(posedge core_clk);
      field_inputs <= ~a;
      repeat (h / 4 + 3) @(posedge core_clk);
      frame((h > 0) ? a : ~a, ~a);
      repeat (h + 12) @(posedge core_clk);
      frame(~a, a);
    end
    // Paired channels: each wired pair reads as two equal bits
    {sel1_oe, sel0_oe, sel_drv} <= 3'b111;
    a = {{2{lfsr_r[3]}}, {2{lfsr_r[2]}}, {2{lfsr_r[1]}}, {2{lfsr_r[0]}}};
    field_inputs <= a;
    repeat (hold_tab[0] + 12) @(posedge core_clk);
    frame(a, a);
    host.load();
    reg_read(`OIS_REG_INPUTS, {16'h0, a, a});
    lvl(2'b01);
    reg_read(`OIS_REG_STATUS, 32'h0000_0002);
    reg_write(`OIS_REG_MASK, 32'h0000_0003);
    lvl(2'b11);
    reg_write(`OIS_REG_STATUS, 32'h0000_0003);
    lvl(2'b01);
    reg_read(`OIS_REG_STATUS, 32'h0000_0000);
    reg_write(`OIS_REG_MASK, 32'h0000_0001);
    temp_c <= 8'h96;
    lvl(2'b01);
    temp_c <= 8'h97;
    lvl(2'b10);
    reg_read(`OIS_REG_TEMP_NOW, 32'h0000_0197);
    reg_read(`OIS_REG_TEMP_TRIP, 32'h0000_0096);
    reg_read(4'hF, 32'h0000_0000);
    reg_read(`OIS_REG_STATUS, 32'h0000_0001);
    temp_c <= 8'h64;
    reg_write(`OIS_REG_STATUS, 32'h0000_0001);
    lvl(2'b01);
    reg_write(`OIS_REG_TEMP_TRIP, 32'h0000_0050);
    lvl(2'b10);
    reg_read(`OIS_REG_STATUS, 32'h0000_0001);
    repeat (3) @(posedge core_clk);
    close_out();
  end
endmodule : octal_input_serializer_bench
